// ### rtl/incap_pkg.sv
// Constants for the digital input capture and routing block.
// Assumes a single clock domain and object-dictionary style register access.
package incap_pkg;

  // Object indices and subindices
  localparam logic [15:0] IDX_CAPTURE      = 16'h3241;  // Capture object
  localparam logic [15:0] IDX_ROUTING      = 16'h3242;  // Routing object
  localparam logic [7:0]  SUB_COUNT        = 8'h00;     // Highest subindex entry
  localparam logic [7:0]  SUB_EDGE_SELECT  = 8'h01;     // Capture control
  localparam logic [7:0]  SUB_EVENT_COUNT  = 8'h02;     // Capture counter
  localparam logic [7:0]  SUB_POS_USER     = 8'h03;     // Position in user units
  localparam logic [7:0]  SUB_POS_RAW      = 8'h04;     // Raw encoder position
  localparam logic [7:0]  SUB_ROUTE_FIRST  = 8'h01;     // First routing selector
  localparam logic [7:0]  SUB_ROUTE_LAST   = 8'h24;     // Last routing selector

  // Reset values
  localparam logic [7:0]  CAPTURE_ENTRIES  = 8'h04;     // Read-only entry count
  localparam logic [7:0]  ROUTING_ENTRIES  = 8'h24;     // Read-only entry count
  localparam logic [31:0] EDGE_SELECT_RST  = 32'h0000_0000;
  localparam logic [31:0] WORD_RST         = 32'h0000_0000;
  localparam logic [7:0]  ROUTE_SEL_RST    = 8'h00;

  // Geometry
  localparam int ROUTE_BITS  = 36;  // Bits of the summarised input word
  localparam int PHYS_INPUTS = 16;  // Physical inputs
  localparam int AUX_INPUTS  = 16;  // Hall, encoder, USB, network, DIP
  localparam int SRC_BITS    = PHYS_INPUTS + AUX_INPUTS;
  localparam int CAPTURE_PIN = 1;   // Digital input 2 sits at bit 1

  // Capture edge selection codes
  typedef enum logic [1:0] {
    EDGE_OFF     = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_mode_t;

  // Routing selector code fields
  localparam logic [6:0] SRC_ZERO      = 7'h00;  // Constant, one when inverted
  localparam logic [6:0] SRC_PHYS_LO   = 7'h01;  // Physical input 1
  localparam logic [6:0] SRC_PHYS_HI   = 7'h10;  // Physical input 16
  localparam logic [6:0] SRC_AUX_LO    = 7'h41;  // Hall U
  localparam logic [6:0] SRC_AUX_HI    = 7'h50;  // DIP switch 8
  localparam int         SEL_INVERT    = 7;      // Inversion flag position

endpackage

// ### rtl/input_capture_and_routing.sv
// Digital input capture of encoder position and summarised input routing.
// Assumes object access from the fieldbus side and positions on clk.
// Pins may change at any time; they are filtered before use.
// Software never raises a read and a write in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module input_capture_and_routing
  import incap_pkg::*;
#(
  parameter int NUM_ROUTES = ROUTE_BITS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Object access port
  input  wire logic [15:0]           obj_index,
  input  wire logic [7:0]            obj_subindex,
  input  wire logic                  obj_wr,
  input  wire logic                  obj_rd,
  input  wire logic [31:0]           obj_wdata,
  output logic [31:0]                obj_rdata,
  output logic                       obj_ack,
  output logic                       obj_err,
  // Pins
  input  wire logic [PHYS_INPUTS-1:0] phys_in,
  input  wire logic [2:0]            hall_uvw,
  input  wire logic [2:0]            enc_abi,
  input  wire logic                  usb_power,
  input  wire logic                  net_active,
  input  wire logic [7:0]            dip_sw,
  // Position sources on clk
  input  wire logic [31:0]           position_actual_user_units,
  input  wire logic [31:0]           position_raw,
  // Results
  output logic [NUM_ROUTES-1:0]      digital_inputs_summary,
  output logic                       capture_pulse
);

  // Synchronised sources, in selector order
  pin_sync_if #(.WIDTH(SRC_BITS)) pins ();
  logic [SRC_BITS-1:0] src_level;  // Clock-aligned source levels

  assign pins.raw  = {dip_sw, net_active, usb_power, enc_abi, hall_uvw, phys_in};
  assign src_level = pins.level;

  // Every source, input 2 among them, is synchronised here
  // Costs four cycles of latency on every routed source
  pin_sync #(
    .WIDTH (SRC_BITS)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .port  (pins)
  );

  // Capture state
  // Every stored entry is software-writable; the pulse is not
  logic [31:0] edge_select;        // Capture control word
  logic [31:0] event_count;        // Captured edge count
  logic [31:0] pos_user;           // Latched user-unit position
  logic [31:0] pos_raw;            // Latched raw position
  logic        din2_prev;          // Input 2 level one cycle ago
  logic        captured;           // Capture happened last cycle
  logic [31:0] next_edge_select;
  logic [31:0] next_event_count;
  logic [31:0] next_pos_user;
  logic [31:0] next_pos_raw;
  logic        next_captured;

  // Access decode
  // Decoded from the strobe cycle alone; nothing is held
  logic        hit_capture;        // Index is the capture object
  logic        hit_routing;        // Index is the routing object
  logic        route_sub_ok;       // Subindex names a selector
  logic [5:0]  route_idx;          // Selector number minus one
  logic        wr_edge;            // Write to capture control
  logic        wr_count;           // Write to capture counter
  logic        wr_user;            // Write to user position
  logic        wr_raw;             // Write to raw position
  logic        wr_route;           // Write to a selector
  logic        acc_ok;             // Access is legal

  // Edge detection
  // Edges come from the filtered level, never the raw pin
  logic        din2;               // Filtered input 2
  logic        rise;               // Rising edge this cycle
  logic        fall;               // Falling edge this cycle
  edge_mode_t  mode;               // Active edge mode
  logic        mode_valid;         // Control holds 1, 2 or 3
  logic        capture;            // Qualifying edge seen

  // Routing state
  // Thirty-six bytes sit in flip-flops; too few for a memory
  logic [7:0]            route_sel [NUM_ROUTES];       // Selectors
  logic [7:0]            next_route_sel [NUM_ROUTES];
  logic [NUM_ROUTES-1:0] route_bits;                   // Mux outputs
  logic [NUM_ROUTES-1:0] summary;                      // Registered word

  // Access answer state
  // Read data holds until the next legal read
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        ack;
  logic        next_ack;
  logic        err;
  logic        next_err;

  // Decode the object address
  always_comb begin
    hit_capture  = (obj_index == IDX_CAPTURE);
    hit_routing  = (obj_index == IDX_ROUTING);
    route_sub_ok = (obj_subindex >= SUB_ROUTE_FIRST) && (obj_subindex <= SUB_ROUTE_LAST);
    // Selector number is the subindex; the selector index is one less
    route_idx    = 6'(obj_subindex - SUB_ROUTE_FIRST);
    // One write strobe per writable capture entry, one shared by all selectors
    wr_edge      = obj_wr && hit_capture && (obj_subindex == SUB_EDGE_SELECT);
    wr_count     = obj_wr && hit_capture && (obj_subindex == SUB_EVENT_COUNT);
    wr_user      = obj_wr && hit_capture && (obj_subindex == SUB_POS_USER);
    wr_raw       = obj_wr && hit_capture && (obj_subindex == SUB_POS_RAW);
    wr_route     = obj_wr && hit_routing && route_sub_ok;
    // Entry counts are read only; writes to them are refused
    if (hit_capture) begin
      // Subindex 00 to 04; the entry count is read only
      acc_ok = (obj_subindex <= SUB_POS_RAW) && !(obj_wr && obj_subindex == SUB_COUNT);
    end else if (hit_routing) begin
      // Entry count read only; selectors both ways
      acc_ok = (obj_subindex == SUB_COUNT) ? !obj_wr : route_sub_ok;
    end else begin
      // Any other object is refused
      acc_ok = 1'b0;
    end
  end

  // Edge qualification on the filtered input 2
  // Rise and fall are exclusive by construction
  always_comb begin
    din2       = src_level[CAPTURE_PIN];
    rise       = din2 && !din2_prev;
    fall       = !din2 && din2_prev;
    // Control values above 3 leave capture off
    mode_valid = (edge_select[31:2] == '0) && (edge_select[1:0] != EDGE_OFF);
    mode       = edge_mode_t'(edge_select[1:0]);
    case (mode)
      EDGE_RISING:  capture = mode_valid && rise;
      EDGE_FALLING: capture = mode_valid && fall;
      EDGE_BOTH:    capture = mode_valid && (rise || fall);
      // Off, by control value or by mode
      default:      capture = 1'b0;
    endcase
  end

  // Next capture state; a capture outranks a position write and adds to a clear or count write of the same cycle
  always_comb begin
    // Hold every entry unless a branch below changes it
    next_edge_select = wr_edge ? obj_wdata : edge_select;
    next_event_count = event_count;
    next_pos_user    = pos_user;
    next_pos_raw     = pos_raw;
    next_captured    = capture;
    // Starting a mode clears the counter
    if (wr_edge && (obj_wdata[31:2] == '0) && (obj_wdata[1:0] != EDGE_OFF)) begin
      next_event_count = WORD_RST;
    end else if (wr_count) begin
      // Software may preset the counter
      next_event_count = obj_wdata;
    end
    // Software writes of the stored positions
    if (wr_user) begin
      next_pos_user = obj_wdata;
    end
    if (wr_raw) begin
      next_pos_raw = obj_wdata;
    end
    // The capture is applied last, so it outranks the position writes and adds to the count
    if (capture) begin
      // Same-cycle clear still leaves this edge counted
      next_event_count = next_event_count + 32'h0000_0001;
      next_pos_user    = position_actual_user_units;
      next_pos_raw     = position_raw;
    end
  end

  // Register capture state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_select <= EDGE_SELECT_RST;
      event_count <= WORD_RST;
      pos_user    <= WORD_RST;
      pos_raw     <= WORD_RST;
      // Starts low, like the filtered level, so no false edge
      din2_prev   <= 1'b0;
      captured    <= 1'b0;
    end else begin
      edge_select <= next_edge_select;
      event_count <= next_event_count;
      pos_user    <= next_pos_user;
      pos_raw     <= next_pos_raw;
      din2_prev   <= din2;
      captured    <= next_captured;
    end
  end

  // Next selector values
  always_comb begin
    for (int i = 0; i < NUM_ROUTES; i++) begin
      // Keep every selector by default
      next_route_sel[i] = route_sel[i];
    end
    if (wr_route) begin
      // Only the addressed selector takes the low byte
      next_route_sel[route_idx] = obj_wdata[7:0];
    end
  end

  // Register selectors and the summary word
  // Summary is registered so the output comes from flip-flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        route_sel[i] <= ROUTE_SEL_RST;
      end
      // Summary starts at zero, as the selectors do
      summary <= '0;
    end else begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        route_sel[i] <= next_route_sel[i];
      end
      summary <= route_bits;
    end
  end

  // One multiplexer per summary bit; selector n feeds bit n-1
  // Unknown codes turn to zero inside each selector
  for (genvar g = 0; g < NUM_ROUTES; g++) begin : g_route
    route_select u_route (
      .sel     (route_sel[g]),
      .sources (src_level),
      .bit_out (route_bits[g])
    );
  end

  // Read data and answer for the access port
  always_comb begin
    next_rdata = rdata;
    // Every strobe is answered; illegal ones with an error
    next_ack   = obj_rd || obj_wr;
    next_err   = (obj_rd || obj_wr) && !acc_ok;
    if (obj_rd && acc_ok) begin
      // Refused reads keep the old data
      next_rdata = '0;
      if (hit_capture) begin
        case (obj_subindex)
          SUB_COUNT:       next_rdata = {24'h00_0000, CAPTURE_ENTRIES};
          SUB_EDGE_SELECT: next_rdata = edge_select;
          SUB_EVENT_COUNT: next_rdata = event_count;
          SUB_POS_USER:    next_rdata = pos_user;
          SUB_POS_RAW:     next_rdata = pos_raw;
          default:         next_rdata = '0;
        endcase
      end else if (obj_subindex == SUB_COUNT) begin
        // Routing entry count
        next_rdata = {24'h00_0000, ROUTING_ENTRIES};
      end else begin
        next_rdata = {24'h00_0000, route_sel[route_idx]};
      end
    end
  end

  // Register the answer
  // Answer flags last one cycle per strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
      ack   <= 1'b0;
      err   <= 1'b0;
    end else begin
      rdata <= next_rdata;
      ack   <= next_ack;
      err   <= next_err;
    end
  end

  // Every output comes straight from a flip-flop
  assign obj_rdata              = rdata;
  assign obj_ack                = ack;
  assign obj_err                = err;
  assign digital_inputs_summary = summary;
  assign capture_pulse          = captured;

endmodule
`default_nettype wire

// ### rtl/pin_sync.sv
// Three-stage pin synchroniser with an agreement filter.
// Assumes pins change freely with respect to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  pin_sync_if.sync    port
);

  logic [WIDTH-1:0] stage1;      // Metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2;      // Second stage
  logic [WIDTH-1:0] stage3;      // Third stage
  logic [WIDTH-1:0] level;       // Accepted level
  logic [WIDTH-1:0] next_level;  // Next accepted level

  // Accept a change once the second and third stage agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
    end
  end

  // Register the chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign port.level = level;

endmodule
`default_nettype wire

// ### rtl/pin_sync_if.sv
// Carrier between the top block and its pin synchroniser.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(
  parameter int WIDTH = 32
);
  logic [WIDTH-1:0] raw;    // Asynchronous pin levels
  logic [WIDTH-1:0] level;  // Filtered, clock-aligned levels

  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface
`default_nettype wire

// ### rtl/route_select.sv
// One routing selector: picks a source bit by its code, maybe inverted.
// Assumes sources are already clock-aligned.
`timescale 1ns/1ps
`default_nettype none
module route_select
  import incap_pkg::*;
(
  input  wire logic [7:0]          sel,
  input  wire logic [SRC_BITS-1:0] sources,
  output logic                     bit_out
);

  logic [6:0] code;     // Code without inversion flag
  logic       defined;  // Code names a real source
  logic       value;    // Source level before inversion

  // Decode the selector
  always_comb begin
    code    = sel[6:0];
    defined = 1'b0;
    value   = 1'b0;
    if (code == SRC_ZERO) begin  // Constant zero, or one when inverted
      defined = 1'b1;
    end else if (code >= SRC_PHYS_LO && code <= SRC_PHYS_HI) begin
      defined = 1'b1;
      value   = sources[4'(code - SRC_PHYS_LO)];
    end else if (code >= SRC_AUX_LO && code <= SRC_AUX_HI) begin
      defined = 1'b1;
      value   = sources[5'(PHYS_INPUTS) + 5'(code - SRC_AUX_LO)];
    end
    // Codes 00/80 give 0/1, 81-90/C1-D0 invert; unknown codes give zero
    bit_out = defined ? (value ^ sel[SEL_INVERT]) : 1'b0;
  end

endmodule
`default_nettype wire

// ### sim/incap_partner.sv
// Far-side model: encoder position counter feeding the capture block.
// Assumes the bench steps the position only while no capture edge is pending.
`timescale 1ns/1ps
`default_nettype none
module incap_partner (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        move,      // Step the position by one count
  output logic [31:0]      pos_raw,   // Unscaled encoder count
  output logic [31:0]      pos_user   // User units, three per count
);
  logic [31:0] next_pos_raw;  // Next counter value

  // Counter steps only on request, so captures see a stable value
  always_comb begin
    next_pos_raw = move ? pos_raw + 32'h0000_0001 : pos_raw;
  end

  // Non-zero start, so a capture that stores nothing is caught
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_raw <= 32'h0000_1000;
    end else begin
      pos_raw <= next_pos_raw;
    end
  end

  // Scaling differs from raw so the two stored entries are told apart
  assign pos_user = {pos_raw[30:0], 1'b0} + pos_raw;
endmodule
`default_nettype wire

// ### sim/input_capture_and_routing_checker.sv
// Port-level assertions for the capture and routing block.
// Assumes one clock and the registered one-cycle object answer.
`timescale 1ns/1ps
`default_nettype none
module input_capture_and_routing_checker
  import incap_pkg::*;
#(
  parameter int NUM_ROUTES = ROUTE_BITS
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [15:0]           obj_index,
  input wire logic [7:0]            obj_subindex,
  input wire logic                  obj_wr,
  input wire logic                  obj_rd,
  input wire logic [31:0]           obj_wdata,
  input wire logic [31:0]           obj_rdata,
  input wire logic                  obj_ack,
  input wire logic                  obj_err,
  input wire logic [NUM_ROUTES-1:0] digital_inputs_summary,
  input wire logic                  capture_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic acc;  // Any request this cycle
  assign acc = obj_wr || obj_rd;

  property p_ack_follows;
    acc |=> obj_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no answer to request");
  property p_no_spur_ack;
    !acc |=> !obj_ack;
  endproperty
  a_no_spur_ack: assert property (p_no_spur_ack) else $error("answer without request");
  // Entry counts are read-only
  property p_sub00_ro;
    obj_wr && obj_subindex == SUB_COUNT |=> obj_ack && obj_err;
  endproperty
  a_sub00_ro: assert property (p_sub00_ro) else $error("entry count writable");
  property p_route_range;
    acc && obj_index == IDX_ROUTING && obj_subindex > 8'h24 |=> obj_err;
  endproperty
  a_route_range: assert property (p_route_range) else $error("selector past 36 taken");
  property p_cap_entries;
    obj_rd && obj_index == IDX_CAPTURE && obj_subindex == SUB_COUNT
      |=> !obj_err && obj_rdata == 32'h0000_0004;
  endproperty
  a_cap_entries: assert property (p_cap_entries) else $error("capture count wrong");
  property p_route_entries;
    obj_rd && obj_index == IDX_ROUTING && obj_subindex == SUB_COUNT
      |=> !obj_err && obj_rdata == 32'h0000_0024;
  endproperty
  a_route_entries: assert property (p_route_entries) else $error("routing count wrong");
  // Constant codes reach bit 0 two edges after the write
  property p_const_one;
    obj_wr && obj_index == IDX_ROUTING && obj_subindex == 8'h01 && obj_wdata[7:0] == 8'h80
      |-> ##2 digital_inputs_summary[0];
  endproperty
  a_const_one: assert property (p_const_one) else $error("code 80 not one");
  property p_const_zero;
    obj_wr && obj_index == IDX_ROUTING && obj_subindex == 8'h01 && obj_wdata[7:0] == 8'h00
      |-> ##2 !digital_inputs_summary[0];
  endproperty
  a_const_zero: assert property (p_const_zero) else $error("code 00 not zero");
  property p_reset_quiet;
    disable iff (1'b0) !rst_n |=> !obj_ack && !capture_pulse && digital_inputs_summary == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");

  c_capture: cover property (capture_pulse);
  c_refused: cover property (obj_ack && obj_err);
  c_write:   cover property (obj_wr ##1 obj_ack);
endmodule

bind input_capture_and_routing input_capture_and_routing_checker #(
  .NUM_ROUTES(NUM_ROUTES)
) u_input_capture_and_routing_checker (
  .clk(clk), .rst_n(rst_n), .obj_index(obj_index), .obj_subindex(obj_subindex),
  .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
  .obj_ack(obj_ack), .obj_err(obj_err),
  .digital_inputs_summary(digital_inputs_summary), .capture_pulse(capture_pulse)
);
`default_nettype wire

// ### sim/input_capture_and_routing_tb_top.sv
// Self-checking bench: routing table, reset values, refusals, capture modes.
// Assumes the far-side position model and pins driven from here.
`timescale 1ns/1ps
`default_nettype none
module input_capture_and_routing_tb_top
  import incap_pkg::*;
;
  logic        clk, rst_n, obj_wr, obj_rd, move, usb_power, net_active, capture_pulse;
  logic        obj_ack, obj_err;
  logic [15:0] obj_index, phys_in;
  logic [7:0]  obj_subindex, dip_sw, mc;
  logic [31:0] obj_wdata, obj_rdata, pos_raw, pos_user, exp_raw, exp_usr, r;
  logic [2:0]  hall_uvw, enc_abi;
  logic [35:0] digital_inputs_summary;
  int          n_fail, check_count, cyc, exp_cnt, n_pulse;
  // Rows {expected bit, selector code} for the fixed pin pattern below
  logic [8:0]  rows [26] = '{9'h000, 9'h101, 9'h002, 9'h110, 9'h041, 9'h142, 9'h043,
    9'h144, 9'h045, 9'h146, 9'h147, 9'h048, 9'h149, 9'h04a, 9'h150, 9'h180, 9'h081,
    9'h182, 9'h090, 9'h1c1, 9'h0c6, 9'h1c8, 9'h0d0, 9'h091, 9'h0d1, 9'h020};

  input_capture_and_routing u_input_capture_and_routing (.clk(clk), .rst_n(rst_n),
    .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .phys_in(phys_in), .hall_uvw(hall_uvw), .enc_abi(enc_abi), .usb_power(usb_power),
    .net_active(net_active), .dip_sw(dip_sw), .position_actual_user_units(pos_user),
    .position_raw(pos_raw), .digital_inputs_summary(digital_inputs_summary),
    .capture_pulse(capture_pulse));
  incap_partner u_incap_partner (.clk(clk), .rst_n(rst_n), .move(move),
    .pos_raw(pos_raw), .pos_user(pos_user));

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One object access; answer sampled once the taking edge has landed
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, input logic e);
    @(posedge clk);
    obj_wr <= w;
    obj_rd <= !w;
    obj_index <= i;
    obj_subindex <= s;
    obj_wdata <= d;
    @(posedge clk);
    obj_wr <= 1'b0;
    obj_rd <= 1'b0;
    #1;
    chk("obj_ack", obj_ack, 1'b1);
    chk("obj_err", obj_err, e);
    r = obj_rdata;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard, far above the expected few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (capture_pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end

  initial begin
    {obj_wr, obj_rd, move, obj_index, obj_subindex, obj_wdata} = '0;
    {n_fail, check_count, cyc, exp_cnt, n_pulse} = '0;
    // Input 1 and 16 high, Hall V, encoder A and index, USB, DIP 1 and 8
    phys_in = 16'h8001;
    hall_uvw = 3'b010;
    enc_abi = 3'b101;
    usb_power = 1'b1;
    net_active = 1'b0;
    dip_sw = 8'h81;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int s = 1; s <= 4; s++) begin
      acc(1'b0, IDX_CAPTURE, s[7:0], 32'h0, 1'b0);
      chk("capture entry", r, 32'h0);
    end
    acc(1'b0, IDX_ROUTING, 8'h24, 32'h0, 1'b0);
    chk("selector 36", r, 32'h0);
    chk("summary", digital_inputs_summary, 36'h0);
    $display("reset test done");
    foreach (rows[k]) begin
      acc(1'b1, IDX_ROUTING, 8'h01, {24'h0, rows[k][7:0]}, 1'b0);
      @(posedge clk);
      #1;
      chk("summary bit 0", digital_inputs_summary[0], rows[k][8]);
      acc(1'b0, IDX_ROUTING, 8'h01, 32'h0, 1'b0);
      chk("selector read", r, {24'h0, rows[k][7:0]});
    end
    $display("routing table done");
    acc(1'b1, IDX_ROUTING, 8'h24, 32'h0000_0080, 1'b0);
    acc(1'b1, IDX_ROUTING, 8'h02, 32'h0000_0080, 1'b0);
    @(posedge clk);
    #1;
    chk("summary ends", digital_inputs_summary, 36'h8_0000_0002);
    acc(1'b0, 16'h1234, 8'h01, 32'h0, 1'b1);
    acc(1'b1, IDX_CAPTURE, SUB_COUNT, 32'h5, 1'b1);
    acc(1'b0, IDX_CAPTURE, 8'h05, 32'h0, 1'b1);
    acc(1'b0, IDX_ROUTING, 8'h25, 32'h0, 1'b1);
    acc(1'b0, IDX_CAPTURE, SUB_COUNT, 32'h0, 1'b0);
    chk("capture entries", r, 32'h4);
    $display("refusal test done");
    // Modes 1, 2, 3 then 0; each sees one rise and one fall on input 2
    for (int m = 0; m < 4; m++) begin
      mc = (m == 3) ? 8'h00 : 8'(m + 1);
      acc(1'b1, IDX_CAPTURE, SUB_EDGE_SELECT, {24'h0, mc}, 1'b0);
      if (mc != 8'h00) exp_cnt = 0;
      for (int t = 0; t < 2; t++) begin
        @(posedge clk);
        phys_in[1] <= ~phys_in[1];
        repeat (8) @(posedge clk);
        if (mc == 8'h03 || (mc == 8'h01 && t == 0) || (mc == 8'h02 && t == 1)) begin
          exp_cnt++;
          exp_raw = pos_raw;
          exp_usr = pos_user;
        end
        move <= 1'b1;
        @(posedge clk);
        move <= 1'b0;
      end
      acc(1'b0, IDX_CAPTURE, SUB_EVENT_COUNT, 32'h0, 1'b0);
      chk("capture count", r, exp_cnt);
      acc(1'b0, IDX_CAPTURE, SUB_POS_USER, 32'h0, 1'b0);
      chk("user position", r, exp_usr);
      acc(1'b0, IDX_CAPTURE, SUB_POS_RAW, 32'h0, 1'b0);
      chk("raw position", r, exp_raw);
    end
    chk("capture pulses", n_pulse, 36'd4);
    $display("capture test done");
    // Software writes, a control above 3, then clear and capture together
    acc(1'b1, IDX_CAPTURE, SUB_EVENT_COUNT, 32'h7, 1'b0);
    acc(1'b1, IDX_CAPTURE, SUB_EDGE_SELECT, 32'h4, 1'b0);
    acc(1'b0, IDX_CAPTURE, SUB_EDGE_SELECT, 32'h0, 1'b0);
    chk("control 4 kept", r, 32'h4);
    acc(1'b0, IDX_CAPTURE, SUB_EVENT_COUNT, 32'h0, 1'b0);
    chk("count not cleared", r, 32'h7);
    acc(1'b1, IDX_CAPTURE, SUB_EDGE_SELECT, 32'h3, 1'b0);
    @(posedge clk);
    phys_in[1] <= ~phys_in[1];
    repeat (3) @(posedge clk);
    // This write is taken at the very edge that stores the capture
    acc(1'b1, IDX_CAPTURE, SUB_EDGE_SELECT, 32'h3, 1'b0);
    acc(1'b0, IDX_CAPTURE, SUB_EVENT_COUNT, 32'h0, 1'b0);
    chk("clear with capture", r, 32'h1);
    chk("capture pulses", n_pulse, 36'h5);
    acc(1'b1, IDX_CAPTURE, SUB_POS_USER, 32'h55, 1'b0);
    acc(1'b1, IDX_CAPTURE, SUB_POS_RAW, 32'h66, 1'b0);
    acc(1'b0, IDX_CAPTURE, SUB_POS_USER, 32'h0, 1'b0);
    chk("user written", r, 32'h55);
    acc(1'b0, IDX_CAPTURE, SUB_POS_RAW, 32'h0, 1'b0);
    chk("raw written", r, 32'h66);
    $display("awkward capture test done");
    // Mid-run reset puts every entry back to its reset value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("rdata after reset", obj_rdata, 36'h0);
    chk("pulse after reset", capture_pulse, 1'b0);
    acc(1'b0, IDX_CAPTURE, SUB_EDGE_SELECT, 32'h0, 1'b0);
    chk("control after reset", r, 32'h0);
    acc(1'b0, IDX_CAPTURE, SUB_EVENT_COUNT, 32'h0, 1'b0);
    chk("count after reset", r, 32'h0);
    acc(1'b0, IDX_ROUTING, 8'h24, 32'h0, 1'b0);
    chk("selector after reset", r, 32'h0);
    chk("summary after reset", digital_inputs_summary, 36'h0);
    acc(1'b1, IDX_ROUTING, SUB_COUNT, 32'h5, 1'b1);
    acc(1'b0, IDX_ROUTING, SUB_COUNT, 32'h0, 1'b0);
    chk("routing entries", r, 32'h24);
    $display("mid-run reset test done");
    close_out;
  end
endmodule
`default_nettype wire
